// ===== src/plr_consts.vh
// register offsets, field positions, reset values for the lock and signal-strength block
`ifndef PLR_CONSTS_VH
`define PLR_CONSTS_VH
// ==========================================
// register map (byte addresses = index * 4)
`define PLR_IDX_CFG 8'h0E
`define PLR_IDX_THR 8'h0F
`define PLR_IDX_ROUTE 8'h40
`define PLR_IDX_STAT 8'h41
// ==========================================
// field positions in fifo_tx_lock_irq_config
`define PLR_BIT_DET_EN 0
`define PLR_BIT_LOCK_STS 1
`define PLR_BIT_SRC_EN 2
// field positions in the routing register
`define PLR_BIT_ROUTE0 0
`define PLR_BIT_ROUTE1 1
// ==========================================
// reset values
`define PLR_RST_CFG 8'h01
`define PLR_RST_THR 8'h00
`define PLR_RST_ROUTE 2'h0
`endif

// ===== src/plr_sync2.v
// two-flop synchroniser for one level
`timescale 1ns/10ps
module plr_sync2 (
  input wire pclk,
  input wire presetn,
  input wire ce,
  input wire d,
  output reg q
);
  reg meta_q;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_q <= 1'b0;
      q <= 1'b0;
    end else if (ce) begin
      meta_q <= d;
      q <= meta_q;
    end
  end
endmodule // plr_sync2

// ===== src/plr_top.v
// lock-detect status and signal-strength interrupt source configuration, APB slave
// What this block does
// - source enable at 0 stops the strength source raising any interrupt request
// - source may stay enabled; routing to line zero and one chosen separately
// - lock status bit 1 reads 1 once lock detected and holds it until cleared, 0 otherwise
// - writing 1 to lock status clears it unless lock is detected in the same cycle; writing 0 does nothing
// - detect enable bit 0 resets to 1; 1 enables, 0 disables detection
// - lock flag drives the indicator pin, which can go high impedance
// - eight-bit threshold register at 0x0F, reset zero, sets comparison level
`timescale 1ns/10ps
`include "plr_consts.vh"
module plr_top (
  input wire pclk,
  input wire presetn,
  input wire ce,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire synth_lock_raw,
  input wire strength_below_thr,
  input wire lock_pin_tristate,
  output reg lock_indicator_pin,
  output reg lock_indicator_pin_oe,
  output reg interrupt_line_zero,
  output reg interrupt_line_one,
  output reg [7:0] strength_threshold_value
);
  // ==========================================
  // input synchronisers
  wire lock_s;
  wire below_s;
  plr_sync2 u_sync_lock (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .d(synth_lock_raw),
    .q(lock_s)
  );
  plr_sync2 u_sync_below (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .d(strength_below_thr),
    .q(below_s)
  );

  // ==========================================
  // constants
  localparam [7:0] CFG_RESET = `PLR_RST_CFG;
  localparam [1:0] ROUTE_RESET = `PLR_RST_ROUTE;
  localparam [7:0] THR_RESET = `PLR_RST_THR;
  localparam [9:0] IDX_CFG = {2'b00, `PLR_IDX_CFG};
  localparam [9:0] IDX_THR = {2'b00, `PLR_IDX_THR};
  localparam [9:0] IDX_ROUTE = {2'b00, `PLR_IDX_ROUTE};
  localparam [9:0] IDX_STAT = {2'b00, `PLR_IDX_STAT};
  localparam ST_IDLE = 1'b0;
  localparam ST_ANSWER = 1'b1;

  // ==========================================
  // declarations
  wire [9:0] idx;
  wire hit_cfg;
  wire hit_thr;
  wire hit_route;
  wire hit_stat;
  wire mapped;
  wire acc;
  wire rd_acc;
  wire wr;
  wire wr_cfg;
  wire wr_thr;
  wire wr_route;
  reg state_q;
  reg state_d;
  reg src_en_q;
  reg det_en_q;
  reg lock_sts_q;
  reg [4:0] cfg_hi_q;
  reg [1:0] route_q;
  wire lock_event;
  wire clr_lock;
  wire src_irq;
  wire [7:0] cfg_word;
  wire [2:0] stat_word;
  wire [1:0] line_d;
  reg [31:0] rdata_d;

  // ==========================================
  // address decode
  assign idx = paddr[11:2];
  assign hit_cfg = (idx == IDX_CFG);
  assign hit_thr = (idx == IDX_THR);
  assign hit_route = (idx == IDX_ROUTE);
  assign hit_stat = (idx == IDX_STAT);
  assign mapped = hit_cfg | hit_thr | hit_route | hit_stat;
  // first access cycle: read data and error are prepared here
  assign acc = psel && penable && (state_q == ST_IDLE);
  assign rd_acc = acc && !pwrite;
  // writes land on the edge at which the master samples pready high
  assign wr = psel && penable && (state_q == ST_ANSWER) && pwrite && mapped;
  assign wr_cfg = wr && hit_cfg;
  assign wr_thr = wr && hit_thr;
  assign wr_route = wr && hit_route;

  // ==========================================
  // handshake: one wait state, then a one-cycle answer
  always @* begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (psel && penable) begin
          state_d = ST_ANSWER;
        end
      end
      ST_ANSWER: begin
        state_d = ST_IDLE;
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= ST_IDLE;
    end else if (ce) begin
      state_q <= state_d;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else if (ce) begin
      pready <= (state_d == ST_ANSWER);
      // an unmapped index is refused; its write never reaches a register
      pslverr <= acc && !mapped;
    end
  end

  // ==========================================
  // lock detection
  assign lock_event = det_en_q && lock_s;
  assign clr_lock = wr_cfg && pwdata[`PLR_BIT_LOCK_STS];

  // set wins over a clear that lands in the same cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lock_sts_q <= CFG_RESET[`PLR_BIT_LOCK_STS];
    end else if (ce) begin
      if (lock_event) begin
        lock_sts_q <= 1'b1;
      end else if (clr_lock) begin
        lock_sts_q <= 1'b0;
      end
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      det_en_q <= CFG_RESET[`PLR_BIT_DET_EN];
    end else if (ce) begin
      if (wr_cfg) begin
        det_en_q <= pwdata[`PLR_BIT_DET_EN];
      end
    end
  end

  // ==========================================
  // signal-strength source enable and routing
  assign src_irq = src_en_q && below_s;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      src_en_q <= CFG_RESET[`PLR_BIT_SRC_EN];
    end else if (ce) begin
      if (wr_cfg) begin
        src_en_q <= pwdata[`PLR_BIT_SRC_EN];
      end
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      route_q <= ROUTE_RESET;
    end else if (ce) begin
      if (wr_route) begin
        route_q <= pwdata[1:0];
      end
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_line
      assign line_d[gi] = src_irq && route_q[gi];
    end
  endgenerate

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      interrupt_line_zero <= 1'b0;
      interrupt_line_one <= 1'b0;
    end else if (ce) begin
      interrupt_line_zero <= line_d[`PLR_BIT_ROUTE0];
      interrupt_line_one <= line_d[`PLR_BIT_ROUTE1];
    end
  end

  // ==========================================
  // threshold and spare configuration storage
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      strength_threshold_value <= THR_RESET;
    end else if (ce) begin
      if (wr_thr) begin
        strength_threshold_value <= pwdata[7:0];
      end
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_hi_q <= CFG_RESET[7:3];
    end else if (ce) begin
      if (wr_cfg) begin
        cfg_hi_q <= pwdata[7:3];
      end
    end
  end

  // ==========================================
  // read-back
  assign cfg_word[7:3] = cfg_hi_q;
  assign cfg_word[`PLR_BIT_SRC_EN] = src_en_q;
  assign cfg_word[`PLR_BIT_LOCK_STS] = lock_sts_q;
  assign cfg_word[`PLR_BIT_DET_EN] = det_en_q;
  assign stat_word = {lock_s, below_s, src_irq};

  always @* begin
    rdata_d = 32'h0000_0000;
    if (rd_acc) begin
      if (hit_cfg) begin
        rdata_d = {24'h00_0000, cfg_word};
      end else if (hit_thr) begin
        rdata_d = {24'h00_0000, strength_threshold_value};
      end else if (hit_route) begin
        rdata_d = {30'h0000_0000, route_q};
      end else if (hit_stat) begin
        rdata_d = {29'h0000_0000, stat_word};
      end
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (ce) begin
      prdata <= rdata_d;
    end
  end

  // ==========================================
  // lock indicator pin and its output enable
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lock_indicator_pin <= 1'b0;
      lock_indicator_pin_oe <= 1'b0;
    end else if (ce) begin
      lock_indicator_pin <= lock_sts_q;
      lock_indicator_pin_oe <= !lock_pin_tristate;
    end
  end
endmodule // plr_top

// ===== tb/plr_top_bench.sv
// bench for the lock and signal-strength block
`timescale 1ns/10ps
module plr_top_bench;
  reg pclk = 0, presetn = 0, ce = 1, psel = 0, penable = 0, pwrite = 0, er;
  reg synth_lock_raw = 0, strength_below_thr = 0, lock_pin_tristate = 0;
  reg [11:0] paddr = 0;
  reg [31:0] pwdata = 0, rd;
  wire [31:0] prdata;
  wire [7:0] strength_threshold_value;
  wire pready, pslverr, lock_indicator_pin, lock_indicator_pin_oe;
  wire interrupt_line_zero, interrupt_line_one;
  integer mismatches = 0, tests_run = 0, cyc = 0;
  plr_top u_plr_top (.*);
  initial forever #5 pclk = ~pclk;
  task chk(input [63:0] nm, input [31:0] e, input [31:0] g);
    begin
      tests_run = tests_run + 1;
      if (g !== e) begin
        mismatches = mismatches + 1;
        $display("MISMATCH %0s exp %h got %h", nm, e, g);
      end
    end
  endtask
  task apb(input w, input [11:0] a, input [31:0] d);
    begin
      @(posedge pclk);
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rd = prdata;
      er = pslverr;
      psel <= 0;
      penable <= 0;
    end
  endtask
  task rc(input [63:0] nm, input [11:0] a, input [31:0] e);
    begin
      apb(0, a, 0);
      chk(nm, e, rd);
    end
  endtask
  task wrap_up;
    begin
      $display("mismatches %0d tests_run %0d", mismatches, tests_run);
      if (mismatches == 0 && tests_run > 0)
        $display("verification passed");
      else
        $display("verification failed");
      $finish;
    end
  endtask
  always @(posedge pclk) begin
    cyc = cyc + 1;
    if (cyc == 3000) begin
      mismatches = mismatches + 1;
      wrap_up;
    end
  end
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1;
    rc("cfg", 12'h038, 32'h0000_0001);
    chk("oe", 1, lock_indicator_pin_oe);
    rc("thr", 12'h03c, 32'h0000_0000);
    apb(1, 12'h03c, 32'h0000_00a5);
    @(posedge pclk);
    chk("thr", 32'h0000_00a5, strength_threshold_value);
    rc("thr", 12'h03c, 32'h0000_00a5);
    synth_lock_raw <= 1;
    repeat (6) @(posedge pclk);
    rc("cfg", 12'h038, 32'h0000_0003);
    chk("pin", 1, lock_indicator_pin);
    synth_lock_raw <= 0;
    apb(1, 12'h038, 32'h0000_0001);
    rc("cfg", 12'h038, 32'h0000_0003);
    apb(1, 12'h038, 32'h0000_0003);
    rc("cfg", 12'h038, 32'h0000_0001);
    chk("pin", 0, lock_indicator_pin);
    apb(1, 12'h038, 32'h0000_0000);
    synth_lock_raw <= 1;
    repeat (6) @(posedge pclk);
    rc("cfg", 12'h038, 32'h0000_0000);
    synth_lock_raw <= 0;
    strength_below_thr <= 1;
    apb(1, 12'h100, 32'h0000_0003);
    apb(1, 12'h038, 32'h0000_0005);
    repeat (4) @(posedge pclk);
    chk("lines", 3, {interrupt_line_one, interrupt_line_zero});
    rc("stat", 12'h104, 32'h0000_0003);
    apb(1, 12'h100, 32'h0000_0001);
    repeat (2) @(posedge pclk);
    chk("lines", 1, {interrupt_line_one, interrupt_line_zero});
    rc("route", 12'h100, 32'h0000_0001);
    apb(1, 12'h038, 32'h0000_0001);
    repeat (2) @(posedge pclk);
    chk("lines", 0, {interrupt_line_one, interrupt_line_zero});
    rc("unmapped", 12'h004, 32'h0000_0000);
    chk("err", 1, er);
    lock_pin_tristate <= 1;
    repeat (2) @(posedge pclk);
    chk("oe", 0, lock_indicator_pin_oe);
    ce <= 0;
    lock_pin_tristate <= 0;
    repeat (3) @(posedge pclk);
    chk("oe", 0, lock_indicator_pin_oe);
    ce <= 1;
    repeat (2) @(posedge pclk);
    chk("oe", 1, lock_indicator_pin_oe);
    wrap_up;
  end
endmodule // plr_top_bench

// ===== tb/plr_top_chk.sv
// port assertions for the lock and signal-strength block
`timescale 1ns/10ps
module plr_top_chk (
  input wire pclk,
  input wire presetn,
  input wire ce,
  input wire psel,
  input wire penable,
  input wire [11:0] paddr,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire synth_lock_raw,
  input wire strength_below_thr,
  input wire lock_pin_tristate,
  input wire lock_indicator_pin,
  input wire lock_indicator_pin_oe,
  input wire interrupt_line_zero
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  AST_RDY: assert property ($rose(penable) && psel |=> pready) else $error("no answer");
  AST_PULSE: assert property (pready |=> !pready) else $error("long ready");
  AST_ERR: assert property (pslverr |-> pready) else $error("stray error");
  AST_RD0: assert property (!pready |-> prdata == 32'h0000_0000) else $error("stray data");
  AST_UNMAP: assert property ($rose(penable) && psel && paddr == 12'h004 |=> pslverr)
    else $error("unmapped accepted");
  AST_OE: assert property ($past(presetn) && $past(ce) |->
    lock_indicator_pin_oe == !$past(lock_pin_tristate))
    else $error("pin enable wrong");
  AST_PIN: assert property ($rose(lock_indicator_pin) |-> $past(synth_lock_raw, 4))
    else $error("pin without lock");
  AST_IRQ: assert property (interrupt_line_zero |-> $past(strength_below_thr, 3))
    else $error("irq without cause");
  cover property (pslverr);
  cover property ($rose(lock_indicator_pin));
  cover property ($rose(interrupt_line_zero));
endmodule // plr_top_chk
bind plr_top plr_top_chk u_chk (.*);
